// File: hdl/xfr_ctrl.sv
`timescale 1ns/1ps
`include "xfr_defs.svh"
module xfr_ctrl
  import xfr_pkg::*;
#(
  parameter int NSRC = 8,
  parameter int VW = 4,
  parameter int RAM_AW = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral activation requests, same clock
  input wire logic [NSRC-1:0] src_req,
  // Requests toward the CPU side
  output logic [NSRC-1:0] src_cpu_irq,
  output logic [NSRC-1:0] src_flag_clr,
  output logic soft_transfer_end_irq,
  // Data memory port
  output xfr_mem_req_t mem_o,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  localparam int RAMN = 1 << RAM_AW;
  localparam int VECN = 1 << VW;
  localparam int SW = $clog2(NSRC + 1);

  // Elaboration check: the decode serves at most 16 slots and 64 words
  if (NSRC < 1 || NSRC > VECN || VW > 4 ||
      RAM_AW < 2 || RAM_AW > 6) begin : g_bad_cfg
    $error("xfr_ctrl: unsupported parameters");
  end

  // ***********************************************
  // Storage
  // ***********************************************
  logic [31:0] ram [RAMN];
  logic [RAM_AW-1:0] vec_tab [VECN];
  logic [NSRC-1:0] source_enable_bank;
  logic soft_trigger_bit;
  logic [6:0] soft_vector;
  logic end_pend;

  // ***********************************************
  // Sequencer state
  // ***********************************************
  xfr_state_t state;
  logic [RAM_AW-1:0] ptr;
  logic [1:0] widx;
  logic [15:0] mode_word;
  logic [23:0] source_pointer;
  logic [23:0] destination_pointer;
  logic [15:0] count_register_a;
  logic act_sw;
  logic [SW-1:0] act_src;
  logic last_done;
  logic [15:0] cost;
  logic [15:0] last_cost;

  // ***********************************************
  // APB decode
  // ***********************************************
  wire setup = psel && !penable;
  wire wr_now = psel && penable && pready && pwrite;
  wire hit_ena = paddr == `XFR_ENA_OFS;
  wire hit_swv = paddr == `XFR_SWV_OFS;
  wire hit_sta = paddr == `XFR_STA_OFS;
  wire hit_vec = paddr >= `XFR_VEC_BASE && paddr < `XFR_VEC_END;
  wire hit_ram = paddr >= `XFR_RAM_BASE && paddr < `XFR_RAM_END;
  wire [3:0] vec_i = paddr[5:2];
  wire [5:0] ram_i = paddr[7:2];
  wire vec_ok = hit_vec && (int'(vec_i) < VECN);
  wire ram_ok = hit_ram && (int'(ram_i) < RAMN);
  wire mapped = hit_ena || hit_swv || hit_sta || vec_ok || ram_ok;
  wire busy = state != XFR_IDLE;
  wire sw_busy = busy && act_sw;
  // Vector may not move while its transfer runs
  wire swv_wr = wr_now && hit_swv && !sw_busy;

  // Read data selection
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit_ena) begin
      rd_mux[NSRC-1:0] = source_enable_bank;
    end else if (hit_swv) begin
      rd_mux[7:0] = {soft_trigger_bit, soft_vector};
    end else if (hit_sta) begin
      rd_mux = {last_cost, 14'h0000, end_pend, busy};
    end else if (vec_ok) begin
      rd_mux[RAM_AW-1:0] = vec_tab[vec_i[VW-1:0]];
    end else if (ram_ok) begin
      rd_mux = ram[ram_i[RAM_AW-1:0]];
    end
  end

  // No wait state: answer is prepared in the setup cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= `XFR_RST_WORD;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= setup && !pwrite ? rd_mux : 32'h0000_0000;
      pslverr <= setup && !mapped;
    end
  end

  // ***********************************************
  // Entry fields and update arithmetic
  // ***********************************************
  wire [1:0] sm = mode_word[`XFR_SM_LSB+:2];
  wire [1:0] dm = mode_word[`XFR_DM_LSB+:2];
  wire [1:0] md = mode_word[`XFR_MD_LSB+:2];
  wire unit_size_bit = mode_word[`XFR_SZ_BIT];
  wire repeat_side_select = mode_word[`XFR_DTS_BIT];
  wire chain_enable = mode_word[`XFR_CE_BIT];
  wire chain_on_zero = mode_word[`XFR_CS_BIT];
  wire per_transfer_irq_select = mode_word[`XFR_DIS_BIT];
  wire is_repeat = md == `XFR_MD_REPEAT;
  wire [23:0] unit = unit_size_bit ? 24'h00_0002 : 24'h00_0001;

  function automatic logic [23:0] xfr_step(input logic [1:0] m,
      input logic [23:0] a, input logic [23:0] d);
    case (m)
      `XFR_STEP_INC: xfr_step = a + d;
      `XFR_STEP_DEC: xfr_step = a - d;
      default: xfr_step = a;
    endcase
  endfunction

  // Counting: normal decrements the full count, repeat the low byte
  wire [15:0] cnt_dec = count_register_a - 16'h0001;
  wire [7:0] low_dec = count_register_a[7:0] - 8'h01;
  wire rep_wrap = is_repeat && low_dec == 8'h00;
  wire [23:0] rep_span = {16'h0000, count_register_a[15:8]} * unit;
  wire [23:0] sp_step = xfr_step(sm, source_pointer, unit);
  wire [23:0] dp_step = xfr_step(dm, destination_pointer, unit);
  wire [23:0] next_sp = rep_wrap && repeat_side_select ?
    sp_step - rep_span : sp_step;
  wire [23:0] next_dp = rep_wrap && !repeat_side_select ?
    dp_step - rep_span : dp_step;
  // Repeat reloads the low byte, so the count never ends there
  wire [15:0] next_cnt = !is_repeat ? cnt_dec :
    {count_register_a[15:8],
     rep_wrap ? count_register_a[15:8] : low_dec};
  wire next_done = !is_repeat && cnt_dec == 16'h0000;

  // Chain continues always, or only on count end
  wire chain_go = chain_enable && (!chain_on_zero || last_done);
  // Final entry with chain set ends silently
  wire fin_irq = !chain_enable &&
    (last_done || per_transfer_irq_select);
  wire [RAM_AW-1:0] wptr = ptr + RAM_AW'(widx);

  // Write-back word selection
  logic [31:0] wb_word;
  always_comb begin
    case (widx)
      2'h0: wb_word = {16'h0000, mode_word};
      2'h1: wb_word = {8'h00, source_pointer};
      2'h2: wb_word = {8'h00, destination_pointer};
      default: wb_word = {16'h0000, count_register_a};
    endcase
  end

  // ***********************************************
  // Activation arbitration
  // ***********************************************
  // A flag being cleared still reads set for one cycle, so mask it
  // to keep the same request from starting a second activation
  wire [NSRC-1:0] pend = src_req & source_enable_bank &
    ~src_flag_clr;
  logic [SW-1:0] pick;
  always_comb begin
    pick = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick = SW'(i);
      end
    end
  end
  // Software start waits until its earlier end is acknowledged
  wire sw_start = soft_trigger_bit && !end_pend;
  wire any_start = |pend || sw_start;
  wire [VW-1:0] vsel = |pend ? VW'(pick) : soft_vector[VW-1:0];

  // ***********************************************
  // Sequencer
  // ***********************************************
  // One cycle per parameter word and per vector read
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= XFR_IDLE;
      widx <= 2'h0;
      ptr <= '0;
    end else begin
      case (state)
        XFR_IDLE: begin
          if (any_start) begin
            state <= XFR_VEC;
          end
        end
        XFR_VEC: begin
          ptr <= vec_tab[vsel];
          widx <= 2'h0;
          state <= XFR_PRD;
        end
        XFR_PRD: begin
          widx <= widx + 2'h1;
          if (widx == 2'h3) begin
            state <= XFR_DRD;
          end
        end
        XFR_DRD: begin
          if (mem_ack) begin
            state <= XFR_DWR;
          end
        end
        XFR_DWR: begin
          if (mem_ack) begin
            widx <= 2'h0;
            state <= XFR_PWB;
          end
        end
        XFR_PWB: begin
          widx <= widx + 2'h1;
          if (widx == 2'h3) begin
            if (chain_go) begin
              ptr <= ptr + RAM_AW'(`XFR_ENTRY_WORDS);
              state <= XFR_PRD;
            end else begin
              state <= XFR_INT;
            end
          end
        end
        XFR_INT: state <= XFR_IDLE;
        default: state <= XFR_IDLE;
      endcase
    end
  end

  // Working copy of the current entry
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_word <= '0;
      source_pointer <= '0;
      destination_pointer <= '0;
      count_register_a <= '0;
      last_done <= 1'b0;
    end else if (state == XFR_PRD) begin
      case (widx)
        2'h0: mode_word <= ram[wptr][15:0];
        2'h1: source_pointer <= ram[wptr][23:0];
        2'h2: destination_pointer <= ram[wptr][23:0];
        default: count_register_a <= ram[wptr][15:0];
      endcase
    end else if (state == XFR_DWR && mem_ack) begin
      source_pointer <= next_sp;
      destination_pointer <= next_dp;
      count_register_a <= next_cnt;
      last_done <= next_done;
    end
  end

  // Data memory request, held until acknowledged
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_o <= '0;
    end else if (state == XFR_PRD && widx == 2'h3) begin
      mem_o <= '{1'b1, 1'b0, unit_size_bit,
        source_pointer, 16'h0000};
    end else if (state == XFR_DRD && mem_ack) begin
      mem_o <= '{1'b1, 1'b1, unit_size_bit, destination_pointer,
        unit_size_bit ? mem_rdata : {8'h00, mem_rdata[7:0]}};
    end else if (state == XFR_DWR && mem_ack) begin
      mem_o <= '0;
    end
  end

  // Parameter RAM: write-back has priority over software
  always_ff @(posedge sys_clk) begin
    if (state == XFR_PWB) begin
      ram[wptr] <= wb_word;
    end else if (wr_now && ram_ok) begin
      ram[ram_i[RAM_AW-1:0]] <= pwdata;
    end
  end

  // Vector slots, written by software only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < VECN; i++) begin
        vec_tab[i] <= '0;
      end
    end else if (wr_now && vec_ok) begin
      vec_tab[vec_i[VW-1:0]] <= pwdata[RAM_AW-1:0];
    end
  end

  // State cost of the activation in progress and the last one
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cost <= '0;
      last_cost <= '0;
      act_sw <= 1'b0;
      act_src <= '0;
    end else if (state == XFR_IDLE) begin
      cost <= '0;
      act_sw <= !(|pend);
      act_src <= pick;
    end else begin
      cost <= cost + 16'h0001;
      if (state == XFR_INT) begin
        last_cost <= cost + 16'h0001;
      end
    end
  end

  // ***********************************************
  // Completion, taken only in the internal operation
  // state, so every entry is already written back
  // ***********************************************
  wire fin = state == XFR_INT;
  wire fin_src = fin && !act_sw;
  wire fin_sw = fin && act_sw;

  // Software trigger, vector and pending end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_trigger_bit <= 1'b0;
      soft_vector <= '0;
      end_pend <= 1'b0;
    end else begin
      if (swv_wr) begin
        soft_trigger_bit <= pwdata[`XFR_TRIG_BIT];
        soft_vector <= pwdata[6:0];
        if (!pwdata[`XFR_TRIG_BIT]) begin
          end_pend <= 1'b0;
        end
      end
      if (fin_sw && fin_irq) begin
        end_pend <= 1'b1;
      end else if (fin_sw) begin
        soft_trigger_bit <= 1'b0;
      end
    end
  end

  // Raised only after completion, never while waiting or running
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_transfer_end_irq <= 1'b0;
    end else begin
      soft_transfer_end_irq <= end_pend && soft_trigger_bit &&
        !(swv_wr && !pwdata[`XFR_TRIG_BIT]);
    end
  end

  // Per-source enable, completion and flag pulses
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    wire mine = fin_src && act_src == SW'(g);
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        source_enable_bank[g] <= 1'b0;
        src_cpu_irq[g] <= 1'b0;
        src_flag_clr[g] <= 1'b0;
      end else begin
        // Software write lands after the clear, so re-enabling wins
        if (mine && fin_irq) begin
          source_enable_bank[g] <= 1'b0;
        end
        if (wr_now && hit_ena) begin
          source_enable_bank[g] <= pwdata[g];
        end
        src_cpu_irq[g] <= mine && fin_irq;
        src_flag_clr[g] <= mine && !fin_irq &&
          !chain_enable;
      end
    end
  end
endmodule

// File: hdl/xfr_defs.svh
`ifndef XFR_DEFS_SVH
`define XFR_DEFS_SVH
// ***********************************************
// Register map (byte addresses, 12-bit decode)
// ***********************************************
`define XFR_ENA_OFS 12'h000
`define XFR_SWV_OFS 12'h004
`define XFR_STA_OFS 12'h008
`define XFR_VEC_BASE 12'h040
`define XFR_VEC_END 12'h080
`define XFR_RAM_BASE 12'h100
`define XFR_RAM_END 12'h200
// ***********************************************
// Field positions
// ***********************************************
`define XFR_TRIG_BIT 7
`define XFR_CE_BIT 15
`define XFR_CS_BIT 14
`define XFR_DIS_BIT 13
`define XFR_SM_LSB 6
`define XFR_DM_LSB 4
`define XFR_MD_LSB 2
`define XFR_SZ_BIT 1
`define XFR_DTS_BIT 0
// ***********************************************
// Codes, reset values and word counts
// ***********************************************
`define XFR_STEP_INC 2'h2
`define XFR_STEP_DEC 2'h3
`define XFR_MD_NORMAL 2'h0
`define XFR_MD_REPEAT 2'h1
`define XFR_RST_WORD 32'h0000_0000
`define XFR_ENTRY_WORDS 3'h4
`endif

// File: hdl/xfr_pkg.sv
package xfr_pkg;
  // Controller sequence, one-hot
  typedef enum logic [6:0] {
    XFR_IDLE = 7'h01,
    XFR_VEC = 7'h02,
    XFR_PRD = 7'h04,
    XFR_DRD = 7'h08,
    XFR_DWR = 7'h10,
    XFR_PWB = 7'h20,
    XFR_INT = 7'h40
  } xfr_state_t;

  // Request toward the data memory port
  typedef struct packed {
    logic req;
    logic we;
    logic word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } xfr_mem_req_t;
endpackage

// File: tb/xfr_ctrl_assertions.sv
`timescale 1ns/1ps
module xfr_ctrl_chk
  import xfr_pkg::*;
#(
  parameter int NSRC = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // CPU side and memory port
  input wire logic [NSRC-1:0] src_cpu_irq,
  input wire logic [NSRC-1:0] src_flag_clr,
  input wire logic soft_transfer_end_irq,
  input wire xfr_mem_req_t mem_o,
  input wire logic mem_ack
);
  logic swv_wr;
  logic [NSRC-1:0] ends;
  // Accepted write to the soft vector register
  assign swv_wr = psel && penable && pready && pwrite && paddr == 12'h004;
  assign ends = src_cpu_irq | src_flag_clr;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_flag_kept: assert property ((src_cpu_irq & src_flag_clr) == '0)
    else $error("flag cleared with irq");
  a_one_source: assert property ($onehot0(ends))
    else $error("several sources ended");
  a_irq_pulse: assert property (src_cpu_irq != '0 |=> src_cpu_irq == '0)
    else $error("irq pulse too long");
  a_after_wback: assert property (ends != '0 |-> !mem_o.req)
    else $error("end while memory busy");
  a_swend_idle: assert property ($rose(soft_transfer_end_irq) |->
    !mem_o.req && ends == '0) else $error("soft end during transfer");
  a_swend_drop: assert property (swv_wr && !pwdata[7] |->
    ##[1:2] !soft_transfer_end_irq) else $error("soft end not dropped");
  a_swend_hold: assert property (soft_transfer_end_irq && !swv_wr |=>
    soft_transfer_end_irq) else $error("soft end lost");
  a_mem_hold: assert property (mem_o.req && !mem_ack |=> $stable(mem_o))
    else $error("memory request changed");
  c_src_irq: cover property (src_cpu_irq != '0);
  c_src_clr: cover property (src_flag_clr != '0);
  c_soft_end: cover property ($rose(soft_transfer_end_irq));
endmodule

bind xfr_ctrl xfr_ctrl_chk #(.NSRC(NSRC)) chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .src_cpu_irq(src_cpu_irq), .src_flag_clr(src_flag_clr),
  .soft_transfer_end_irq(soft_transfer_end_irq), .mem_o(mem_o),
  .mem_ack(mem_ack)
);

// File: tb/xfr_mem_model.sv
`timescale 1ns/1ps
module xfr_mem_model
  import xfr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Memory port
  input wire xfr_mem_req_t mem_o,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  // Source request flags
  input wire logic [7:0] flag_set,
  input wire logic [7:0] flag_done,
  input wire logic [7:0] src_flag_clr,
  output logic [7:0] src_req,
  // Last data write seen
  output logic [23:0] wr_addr,
  output logic [15:0] wr_data
);
  logic [1:0] waits;
  logic slow;
  // Ack after 0 or 3 waits in turn, so fast and slow answers are both seen
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'h0;
      waits <= 2'h0;
      slow <= 1'h0;
      mem_rdata <= 16'h0000;
      wr_addr <= 24'h000000;
      wr_data <= 16'h0000;
    end else if (mem_o.req && !mem_ack && waits == {slow, slow}) begin
      mem_ack <= 1'h1;
      waits <= 2'h0;
      slow <= !slow;
      mem_rdata <= {~mem_o.addr[7:0], mem_o.addr[7:0] ^ 8'h5A};
      if (mem_o.we) begin
        wr_addr <= mem_o.addr;
        wr_data <= mem_o.wdata;
      end
    end else begin
      mem_ack <= 1'h0;
      waits <= (mem_o.req && !mem_ack) ? waits + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata; // Released bus never holds old data
    end
  end
  // Flag stays set until the controller or the handler clears it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_req <= 8'h00;
    end else begin
      src_req <= (src_req | flag_set) & ~src_flag_clr & ~flag_done;
    end
  end
endmodule

// File: tb/test_transfer_ctrl_activation_end.sv
`timescale 1ns/1ps
`include "xfr_defs.svh"
module test_transfer_ctrl_activation_end
  import xfr_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } xfr_row_t;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, soft_transfer_end_irq, mem_ack, e;
  logic [7:0] src_req, src_cpu_irq, src_flag_clr;
  logic [7:0] flag_set = 8'h00;
  logic [7:0] flag_done = 8'h00;
  xfr_mem_req_t mem_o;
  logic [15:0] mem_rdata, wr_data;
  logic [23:0] wr_addr;
  int n_errors = 0;
  int checked = 0;
  int n_irq = 0;
  int n_clr = 0;
  xfr_row_t rows [7] = '{
    '{1'h0, `XFR_ENA_OFS, 32'h0, 32'h0, 1'h0},
    '{1'h0, `XFR_SWV_OFS, 32'h0, 32'h0, 1'h0},
    '{1'h0, `XFR_STA_OFS, 32'h0, 32'h0, 1'h0},
    '{1'h1, `XFR_VEC_BASE, 32'h5, 32'h0, 1'h0},
    '{1'h0, `XFR_VEC_BASE, 32'h0, 32'h5, 1'h0},
    '{1'h0, 12'h010, 32'h0, 32'h0, 1'h1},
    '{1'h1, 12'h00C, 32'h1, 32'h0, 1'h1}};

  xfr_ctrl uut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_req(src_req), .src_cpu_irq(src_cpu_irq),
    .src_flag_clr(src_flag_clr),
    .soft_transfer_end_irq(soft_transfer_end_irq), .mem_o(mem_o),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  xfr_mem_model mdl (.sys_clk(sys_clk), .rst_b(rst_b), .mem_o(mem_o),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .flag_set(flag_set),
    .flag_done(flag_done), .src_flag_clr(src_flag_clr),
    .src_req(src_req), .wr_addr(wr_addr), .wr_data(wr_data));

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // Count completion pulses toward the CPU
  always @(posedge sys_clk) begin
    n_irq <= n_irq + $countones(src_cpu_irq);
    n_clr <= n_clr + $countones(src_flag_clr);
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; only the watchdog bounds the wait for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'h1);
    rv = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task ent(input logic [11:0] w, input logic [15:0] md,
           input logic [23:0] s, t, input logic [15:0] c);
    apb(1'h1, `XFR_RAM_BASE + (w << 2), {16'h0, md});
    apb(1'h1, `XFR_RAM_BASE + (w << 2) + 12'h4, {8'h0, s});
    apb(1'h1, `XFR_RAM_BASE + (w << 2) + 12'h8, {8'h0, t});
    apb(1'h1, `XFR_RAM_BASE + (w << 2) + 12'hC, {16'h0, c});
  endtask
  // Poll busy until the activation has finished
  task fin();
    int k;
    repeat (4) @(posedge sys_clk);
    k = 0;
    do begin
      apb(1'h0, `XFR_STA_OFS, 32'h0);
      k++;
    end while (rv[0] !== 1'h0 && k < 100);
    check(rv[0], 1'h0);
  endtask
  task raise(input logic [7:0] m);
    @(posedge sys_clk);
    flag_set <= m;
    @(posedge sys_clk);
    flag_set <= 8'h00;
    fin();
  endtask
  task handled(input logic [7:0] m);
    @(posedge sys_clk);
    flag_done <= m;
    @(posedge sys_clk);
    flag_done <= 8'h00;
  endtask
  task test_done();
    $display("Checks %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog far beyond the expected run length
  initial begin
    #400000;
    n_errors++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'h1;
    for (int i = 0; i < 7; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      check(e, rows[i].e);
      if (!rows[i].w) check(rv, rows[i].x);
    end
    $display("Register table done");
    // Source 3, normal byte, dest increments, two transfers
    apb(1'h1, `XFR_VEC_BASE + 12'hC, 32'h0);
    ent(12'h0, 16'h0020, 24'h000300, 24'h001000, 16'h0002);
    apb(1'h1, `XFR_ENA_OFS, 32'h08);
    raise(8'h08);
    // Vector 1, 4 reads, read 2, write 5, 4 write-backs, internal 1
    check(rv[31:16], 16'h0011);
    check(n_clr, 1);
    check(n_irq, 0);
    check({8'h0, wr_addr}, 32'h001000);
    check(wr_data[7:0], 8'h5A);
    raise(8'h08);
    check(n_irq, 1);
    check(n_clr, 1);
    check(src_req, 8'h08);
    check({8'h0, wr_addr}, 32'h001001);
    apb(1'h0, `XFR_ENA_OFS, 32'h0);
    check(rv, 32'h0);
    apb(1'h0, `XFR_RAM_BASE + 12'hC, 32'h0);
    check(rv[15:0], 16'h0000);
    handled(8'h08);
    $display("Count end test done");
    // Source 5 with per-transfer select, then re-enabled
    apb(1'h1, `XFR_VEC_BASE + 12'h14, 32'h4);
    ent(12'h4, 16'h2020, 24'h000400, 24'h002000, 16'h0005);
    apb(1'h1, `XFR_ENA_OFS, 32'h20);
    raise(8'h20);
    check(n_irq, 2);
    check(n_clr, 1);
    apb(1'h0, `XFR_ENA_OFS, 32'h0);
    check(rv, 32'h0);
    apb(1'h0, `XFR_RAM_BASE + 12'h1C, 32'h0);
    check(rv[15:0], 16'h0004);
    apb(1'h1, `XFR_ENA_OFS, 32'h20);
    fin();
    check(n_irq, 3);
    handled(8'h20);
    $display("Select test done");
    // Software start, first without then with select
    apb(1'h1, `XFR_VEC_BASE + 12'h8, 32'h8);
    ent(12'h8, 16'h0020, 24'h000500, 24'h003000, 16'h0003);
    apb(1'h0, `XFR_SWV_OFS, 32'h0);
    check(rv[7], 1'h0);
    apb(1'h1, `XFR_SWV_OFS, 32'h82);
    apb(1'h0, `XFR_SWV_OFS, 32'h0);
    check(rv[6:0], 7'h02);
    fin();
    apb(1'h0, `XFR_SWV_OFS, 32'h0);
    check(rv, 32'h02);
    check(soft_transfer_end_irq, 1'h0);
    ent(12'h8, 16'h2020, 24'h000500, 24'h003000, 16'h0003);
    apb(1'h1, `XFR_SWV_OFS, 32'h82);
    fin();
    apb(1'h0, `XFR_SWV_OFS, 32'h0);
    check(rv, 32'h82);
    check(soft_transfer_end_irq, 1'h1);
    check(n_irq, 3);
    apb(1'h0, `XFR_STA_OFS, 32'h0);
    check(rv[1], 1'h1);
    apb(1'h1, `XFR_SWV_OFS, 32'h0);
    repeat (2) @(posedge sys_clk);
    check(soft_transfer_end_irq, 1'h0);
    $display("Software test done");
    // Source 1 in repeat mode: count reloads, never ends
    apb(1'h1, `XFR_VEC_BASE + 12'h4, 32'hC);
    ent(12'hC, 16'h0024, 24'h000600, 24'h004000, 16'h0202);
    apb(1'h1, `XFR_ENA_OFS, 32'h02);
    raise(8'h02);
    raise(8'h02);
    apb(1'h0, `XFR_RAM_BASE + 12'h3C, 32'h0);
    check(rv[15:0], 16'h0202);
    check(n_irq, 3);
    check(n_clr, 3);
    apb(1'h0, `XFR_ENA_OFS, 32'h0);
    check(rv, 32'h02);
    $display("Repeat test done");
    // Source 6: chained word entry, then a normal byte entry
    apb(1'h1, `XFR_VEC_BASE + 12'h18, 32'h10);
    ent(12'h10, 16'hA082, 24'h000700, 24'h004800, 16'h0001);
    ent(12'h14, 16'h0020, 24'h000800, 24'h005000, 16'h0005);
    apb(1'h1, `XFR_ENA_OFS, 32'h40);
    raise(8'h40);
    check(n_irq, 3);
    check(n_clr, 4);
    check({8'h0, wr_addr}, 32'h005000);
    apb(1'h0, `XFR_RAM_BASE + 12'h44, 32'h0);
    check(rv, 32'h000702);
    apb(1'h0, `XFR_ENA_OFS, 32'h0);
    check(rv, 32'h40);
    $display("Chain test done");
    // Reset while idle clears the enables and the trigger
    @(posedge sys_clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'h1;
    apb(1'h0, `XFR_ENA_OFS, 32'h0);
    check(rv, 32'h0);
    apb(1'h0, `XFR_SWV_OFS, 32'h0);
    check(rv, 32'h0);
    check(soft_transfer_end_irq, 1'h0);
    $display("Reset test done");
    test_done();
  end
endmodule
